// File: design/iwd_pkg.sv
// Purpose: shared constants for the instruction word decode/execute block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: register offsets are byte addresses on the apb bus
package iwd_pkg;
	localparam int IW = 14;
	localparam int DW = 8;
	localparam int AW = 7;
	localparam int PCW = 11;
	localparam int Q_PER_CYCLE = 4;
	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INSTR = 8'h04;
	localparam logic [7:0] OFS_ACC = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_OPTION = 8'h10;
	localparam logic [7:0] OFS_PC = 8'h14;
	localparam logic [7:0] OFS_FADDR = 8'h18;
	localparam logic [7:0] OFS_FDATA = 8'h1c;
	localparam logic [7:0] OFS_STACK = 8'h20;
	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_DCARRY = 1;
	localparam int ST_Z = 2;
	localparam int ST_IRQEN = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_ILL = 5;
	localparam logic [7:0] OPTION_RST = 8'hff;
	// opcode fields
	localparam logic [5:0] OP_ADD_FILE = 6'h07;
	localparam logic [5:0] OP_AND_FILE = 6'h05;
	localparam logic [5:0] OP_MOVE_FILE = 6'h08;
	localparam logic [5:0] OP_ZERO = 6'h00;
	localparam logic [5:0] OP_AND_LIT = 6'h39;
	localparam logic [4:0] OP_ADD_LIT = 5'h1f;
	localparam logic [7:0] LO_OPTION = 8'h62;
	localparam logic [7:0] LO_RETI = 8'h09;
	typedef enum logic [3:0] {
		IWD_NOP, IWD_ADDL, IWD_ADDF, IWD_ANDL, IWD_ANDF,
		IWD_MOVFILE, IWD_MOVACC, IWD_OPT, IWD_RETI, IWD_ILL
	} iwd_op_e;
endpackage

// File: design/iwd_dec_if.sv
// Purpose: decoded instruction fields between decoder and core
// Assumes: one word decoded per instruction cycle
// Notes: none
`timescale 1ns/1ps
interface iwd_dec_if;
	logic [13:0] word;
	iwd_pkg::iwd_op_e op;
	logic dest_f;
	logic [6:0] faddr;
	logic [2:0] bitsel;
	logic [7:0] lit;
	modport dec (input word, output op, dest_f, faddr, bitsel, lit);
	modport core (output word, input op, dest_f, faddr, bitsel, lit);
endinterface

// File: design/iwd_decoder.sv
// Purpose: combinational decode of one 14-bit instruction word
// Assumes: don't-care bits may hold either value
// Notes: unknown patterns decode as illegal, set the ill status bit and only advance the pc
`timescale 1ns/1ps
module iwd_decoder (
	iwd_dec_if.dec d
);
	logic [5:0] hi;
	logic [7:0] lo;
	assign hi = d.word[13:8];
	assign lo = d.word[7:0];
	assign d.dest_f = d.word[7];
	assign d.faddr = d.word[6:0];
	assign d.bitsel = d.word[9:7];
	assign d.lit = lo;

	always_comb
	begin
		d.op = iwd_pkg::IWD_ILL;
		// bit 8 of add-literal and bits 6:5 of no-op are ignored
		if (hi[5:1] == iwd_pkg::OP_ADD_LIT)
			d.op = iwd_pkg::IWD_ADDL;
		else if (hi == iwd_pkg::OP_AND_LIT)
			d.op = iwd_pkg::IWD_ANDL;
		else if (hi == iwd_pkg::OP_ADD_FILE)
			d.op = iwd_pkg::IWD_ADDF;
		else if (hi == iwd_pkg::OP_AND_FILE)
			d.op = iwd_pkg::IWD_ANDF;
		else if (hi == iwd_pkg::OP_MOVE_FILE)
			d.op = iwd_pkg::IWD_MOVFILE;
		else if (hi == iwd_pkg::OP_ZERO)
		begin
			if (lo[7])
				d.op = iwd_pkg::IWD_MOVACC;
			else if (lo == iwd_pkg::LO_OPTION)
				d.op = iwd_pkg::IWD_OPT;
			else if (lo == iwd_pkg::LO_RETI)
				d.op = iwd_pkg::IWD_RETI;
			else if (lo[4:0] == 5'h00 && !lo[7])
				d.op = iwd_pkg::IWD_NOP;
		end
	end
endmodule

// File: design/iwd_core.sv
// Purpose: decode-and-execute core for 14-bit instruction words
// Assumes: apb master software loads words and file data
// Notes: file store is a small flop array, one apb port into it
//
// Operation
// - fetch and decode one 14-bit word
// - d=0 result to accumulator, d=1 to file
// - seven-bit file address, 0 to 0x7f
// - bit field picks one of eight bits
// - one cycle; pc change takes two, nop second
// - instruction cycle is four clock periods
// - add-literal updates acc, c, dc, z
// - add acc and file, c, dc, z
// - and-literal into acc, only z
// - and acc with file, only z
// - move acc to file, no flags
// - load-option copies acc into option
// - interrupt-return pops stack, sets irq enable
// - don't-care bits ignored by decoder
`timescale 1ns/1ps
module iwd_core #(
	parameter int NFILE = 128
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// execution state
	output logic [7:0] ACC,
	output logic BUSY
);
	iwd_dec_if dif ();
	iwd_decoder u_dec (.d(dif));

	logic [13:0] instr_q;
	logic [7:0] acc_q;
	logic carry_q, digit_carry_flag_q, zero_q, global_irq_enable_q;
	logic [7:0] option_q;
	logic [10:0] pc_q, return_stack_top_q;
	logic [7:0] file_q [NFILE];
	logic [6:0] faddr_q;
	logic [1:0] qph_q;
	logic busy_q, second_q, ill_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	assign dif.word = instr_q;
	assign ACC = acc_q;
	assign BUSY = busy_q;
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;

	logic apb_acc, apb_wr, go, last_q;
	assign apb_acc = PSEL && PENABLE && !pready_q;
	assign apb_wr = apb_acc && PWRITE;
	assign go = apb_wr && PADDR == iwd_pkg::OFS_CTRL && PWDATA[0] && !busy_q;
	// execution happens at the last quarter of the instruction cycle
	assign last_q = busy_q && qph_q == 2'(iwd_pkg::Q_PER_CYCLE - 1);

	// operand and alu
	logic [7:0] fval, res;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] src;
	always_comb
	begin
		fval = file_q[dif.faddr];
		src = (dif.op == iwd_pkg::IWD_ADDL || dif.op == iwd_pkg::IWD_ANDL)
			? dif.lit : fval;
		sum = {1'b0, acc_q} + {1'b0, src};
		nib = {1'b0, acc_q[3:0]} + {1'b0, src[3:0]};
		case (dif.op)
			iwd_pkg::IWD_ADDL, iwd_pkg::IWD_ADDF: res = sum[7:0];
			iwd_pkg::IWD_ANDL, iwd_pkg::IWD_ANDF: res = acc_q & src;
			iwd_pkg::IWD_MOVFILE: res = fval;
			default: res = acc_q;
		endcase
	end

	logic to_acc, to_file;
	always_comb
	begin
		to_acc = 1'b0;
		to_file = 1'b0;
		case (dif.op)
			iwd_pkg::IWD_ADDL, iwd_pkg::IWD_ANDL: to_acc = 1'b1;
			iwd_pkg::IWD_ADDF, iwd_pkg::IWD_ANDF, iwd_pkg::IWD_MOVFILE:
			begin
				to_acc = !dif.dest_f;
				to_file = dif.dest_f;
			end
			iwd_pkg::IWD_MOVACC: to_file = 1'b1;
			default:
			begin
				to_acc = 1'b0;
				to_file = 1'b0;
			end
		endcase
	end

	logic exec;
	assign exec = last_q && !second_q;

	// quarter-cycle sequencer
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			qph_q <= 2'h0;
		else if (!busy_q)
			qph_q <= 2'h0;
		else
			qph_q <= qph_q + 2'h1;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			busy_q <= 1'b0;
			second_q <= 1'b0;
		end
		else if (go)
			busy_q <= 1'b1;
		else if (exec && dif.op == iwd_pkg::IWD_RETI)
			second_q <= 1'b1;
		else if (last_q)
		begin
			busy_q <= 1'b0;
			second_q <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			acc_q <= 8'h00;
		else if (apb_wr && PADDR == iwd_pkg::OFS_ACC && !busy_q)
			acc_q <= PWDATA[7:0];
		else if (exec && to_acc)
			acc_q <= res;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			carry_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
			zero_q <= 1'b0;
		end
		else if (exec)
			case (dif.op)
				iwd_pkg::IWD_ADDL, iwd_pkg::IWD_ADDF:
				begin
					carry_q <= sum[8];
					digit_carry_flag_q <= nib[4];
					zero_q <= res == 8'h00;
				end
				iwd_pkg::IWD_ANDL, iwd_pkg::IWD_ANDF, iwd_pkg::IWD_MOVFILE:
					zero_q <= res == 8'h00;
				default: zero_q <= zero_q;
			endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			option_q <= iwd_pkg::OPTION_RST;
		else if (apb_wr && PADDR == iwd_pkg::OFS_OPTION && !busy_q)
			option_q <= PWDATA[7:0];
		else if (exec && dif.op == iwd_pkg::IWD_OPT)
			option_q <= acc_q;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pc_q <= 11'h000;
			global_irq_enable_q <= 1'b0;
			ill_q <= 1'b0;
		end
		else if (apb_wr && PADDR == iwd_pkg::OFS_STATUS && !busy_q)
		begin
			global_irq_enable_q <= PWDATA[iwd_pkg::ST_IRQEN];
			ill_q <= 1'b0;
		end
		else if (exec && dif.op == iwd_pkg::IWD_RETI)
		begin
			pc_q <= return_stack_top_q;
			global_irq_enable_q <= 1'b1;
		end
		else if (exec)
		begin
			pc_q <= pc_q + 11'h001;
			ill_q <= dif.op == iwd_pkg::IWD_ILL;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			instr_q <= 14'h0000;
			faddr_q <= 7'h00;
			return_stack_top_q <= 11'h000;
		end
		else if (apb_wr && !busy_q)
			case (PADDR)
				iwd_pkg::OFS_INSTR: instr_q <= PWDATA[13:0];
				iwd_pkg::OFS_FADDR: faddr_q <= PWDATA[6:0];
				iwd_pkg::OFS_STACK: return_stack_top_q <= PWDATA[10:0];
				default: faddr_q <= faddr_q;
			endcase
	end

	// file store: one flop word per entry
	generate
		for (genvar i = 0; i < NFILE; i++)
		begin : g_file
			always_ff @(posedge SYS_CLK or negedge RST_N)
			begin
				if (!RST_N)
					file_q[i] <= 8'h00;
				else if (apb_wr && !busy_q && PADDR == iwd_pkg::OFS_FDATA
					&& faddr_q == 7'(i))
					file_q[i] <= PWDATA[7:0];
				else if (exec && to_file && dif.faddr == 7'(i))
					file_q[i] <= res;
			end
		end
	endgenerate

	// apb: one wait state, ready on the second access cycle
	logic [31:0] rd;
	always_comb
	begin
		rd = 32'h0;
		case (PADDR)
			iwd_pkg::OFS_CTRL: rd = {31'h0, busy_q};
			iwd_pkg::OFS_INSTR: rd = {18'h0, instr_q};
			iwd_pkg::OFS_ACC: rd = {24'h0, acc_q};
			iwd_pkg::OFS_STATUS: rd = {26'h0, ill_q, busy_q,
				global_irq_enable_q, zero_q, digit_carry_flag_q, carry_q};
			iwd_pkg::OFS_OPTION: rd = {24'h0, option_q};
			iwd_pkg::OFS_PC: rd = {21'h0, pc_q};
			iwd_pkg::OFS_FADDR: rd = {25'h0, faddr_q};
			iwd_pkg::OFS_FDATA: rd = {24'h0, file_q[faddr_q]};
			iwd_pkg::OFS_STACK: rd = {21'h0, return_stack_top_q};
			default: rd = 32'h0;
		endcase
	end

	logic mapped;
	assign mapped = PADDR[1:0] == 2'h0 && PADDR <= iwd_pkg::OFS_STACK;

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else
		begin
			pready_q <= apb_acc;
			pslverr_q <= apb_acc && !mapped;
			prdata_q <= apb_acc && !PWRITE ? rd : 32'h0;
		end
	end

	chk_exec_four: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(go && dif.op != iwd_pkg::IWD_RETI)
		|=> busy_q [*4] ##1 !busy_q)
		else $error("one-cycle instruction did not take four clocks");
	chk_reti_two: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(go && dif.op == iwd_pkg::IWD_RETI) |=> busy_q [*8] ##1 !busy_q)
		else $error("interrupt return did not take eight clocks");
	chk_reti_gie: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_RETI) |=> global_irq_enable_q
		&& pc_q == $past(return_stack_top_q))
		else $error("interrupt return did not pop and enable");
	chk_addl_sum: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_ADDL) |=> acc_q ==
		8'($past(acc_q) + $past(instr_q[7:0])))
		else $error("add literal result wrong");
	chk_andl_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_ANDL) |=> $stable(carry_q)
		&& zero_q == (acc_q == 8'h00))
		else $error("and literal flags wrong");
	chk_acc_to_file: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_MOVACC) |=> $stable(zero_q)
		&& file_q[$past(dif.faddr)] == $past(acc_q))
		else $error("move acc to file wrong");
	chk_dest_acc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_ADDF && !dif.dest_f)
		|=> file_q[$past(dif.faddr)] == $past(fval))
		else $error("d=0 result reached file");
	chk_opt_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_OPT) |=> option_q == $past(acc_q)
		&& $stable(zero_q))
		else $error("option load wrong");
	chk_nop_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(exec && dif.op == iwd_pkg::IWD_NOP) |=> $stable(acc_q)
		&& $stable(zero_q) && pc_q == 11'($past(pc_q) + 11'h001))
		else $error("no-op changed state");
endmodule

// File: tb/iwd_host.sv
// Purpose: apb master standing in for software and program memory
// Assumes: one transfer at a time, slave inserts wait states freely
// Notes: signals change only by nba just after a rising edge
`timescale 1ns/1ps
module iwd_host (
	// clock
	input wire logic clk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int timeouts = 0;
	logic last_err = 1'b0;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// words travel whole in pwdata[13:0], upper bits zero
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		// idle edge first, so a strobe is never set twice in one step
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			timeouts++;
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data is inverted so a stale value is never trusted
		pwdata <= ~d;
	endtask
endmodule

// File: tb/instr_word_decode_exec_tb_top.sv
// Purpose: self-checking bench for the decode/execute core
// Assumes: single step, one instruction at a time
// Notes: expectations are worked out by hand from the operands
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
$display("ERROR %s exp %h seen %h", n, e, s); end end
module instr_word_decode_exec_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, busy;
	logic [7:0] paddr, acc;
	logic [31:0] pwdata, prdata, q;
	logic [10:0] pc0;
	int fails = 0;
	int n_tests = 0;
	always #50 sys_clk = ~sys_clk;
	iwd_core u_iwd_core (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ACC(acc), .BUSY(busy));
	iwd_host u_iwd_host (.clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_iwd_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		u_iwd_host.xfer(1'b0, a, 32'h0, q);
	endtask
	// start one word and count the edges until busy drops
	task automatic run(input logic [13:0] w, input int cyc);
		int n;
		n = 0;
		wr(iwd_pkg::OFS_INSTR, {18'h0, w});
		wr(iwd_pkg::OFS_CTRL, 32'h1);
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (busy === 1'b1 && n < 20);
		`CHK("busy cycles", cyc, n)
		if (n >= 20 || u_iwd_host.timeouts != 0)
		begin
			fails++;
			final_report();
		end
	endtask
	task automatic chk_st(input logic [3:0] e);
		rd(iwd_pkg::OFS_STATUS);
		`CHK("status", e, q[3:0])
	endtask
	task automatic t_reset();
		`CHK("acc reset", 8'h00, acc)
		rd(iwd_pkg::OFS_OPTION);
		`CHK("option reset", 8'hff, q[7:0])
		rd(8'h40);
		`CHK("unmapped err", 1'b1, u_iwd_host.last_err)
		`CHK("unmapped data", 32'h0, q)
		$display("test reset done");
	endtask
	task automatic t_add();
		wr(iwd_pkg::OFS_ACC, 32'h10);
		run(14'h3f15, 4);
		`CHK("addl acc", 8'h25, acc)
		chk_st(4'h0);
		wr(iwd_pkg::OFS_ACC, 32'h08);
		run(14'h3ef8, 4);
		`CHK("addl wrap", 8'h00, acc)
		chk_st(4'h7);
		wr(iwd_pkg::OFS_FADDR, 32'h7f);
		wr(iwd_pkg::OFS_FDATA, 32'hc2);
		wr(iwd_pkg::OFS_ACC, 32'h17);
		run(14'h077f, 4);
		`CHK("addf to acc", 8'hd9, acc)
		chk_st(4'h0);
		run(14'h07ff, 4);
		rd(iwd_pkg::OFS_FDATA);
		`CHK("addf to file", 8'h9b, q[7:0])
		`CHK("addf acc kept", 8'hd9, acc)
		chk_st(4'h1);
		$display("test add done");
	endtask
	task automatic t_and();
		wr(iwd_pkg::OFS_ACC, 32'ha3);
		run(14'h395f, 4);
		`CHK("andl acc", 8'h03, acc)
		chk_st(4'h1);
		wr(iwd_pkg::OFS_FADDR, 32'h10);
		wr(iwd_pkg::OFS_FDATA, 32'hc2);
		wr(iwd_pkg::OFS_ACC, 32'h17);
		run(14'h0590, 4);
		rd(iwd_pkg::OFS_FDATA);
		`CHK("andf file", 8'h02, q[7:0])
		`CHK("andf acc kept", 8'h17, acc)
		run(14'h3900, 4);
		chk_st(4'h5);
		$display("test and done");
	endtask
	task automatic t_move();
		run(14'h0810, 4);
		`CHK("move file acc", 8'h02, acc)
		chk_st(4'h1);
		run(14'h00a0, 4);
		chk_st(4'h1);
		wr(iwd_pkg::OFS_FADDR, 32'h20);
		rd(iwd_pkg::OFS_FDATA);
		`CHK("acc to file", 8'h02, q[7:0])
		wr(iwd_pkg::OFS_ACC, 32'h4f);
		run(14'h0062, 4);
		rd(iwd_pkg::OFS_OPTION);
		`CHK("option load", 8'h4f, q[7:0])
		rd(iwd_pkg::OFS_PC);
		pc0 = q[10:0];
		// bits 6:5 set on purpose, they must not matter
		run(14'h0060, 4);
		rd(iwd_pkg::OFS_PC);
		`CHK("nop pc", pc0 + 11'h1, q[10:0])
		`CHK("nop acc", 8'h4f, acc)
		chk_st(4'h1);
		$display("test move done");
	endtask
	task automatic t_reti();
		wr(iwd_pkg::OFS_STACK, 32'h123);
		run(14'h0009, 8);
		rd(iwd_pkg::OFS_PC);
		`CHK("reti pc", 11'h123, q[10:0])
		chk_st(4'h9);
		$display("test reti done");
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_add();
		t_and();
		t_move();
		t_reti();
		fails += u_iwd_host.timeouts;
		final_report();
	end
endmodule
